// >>> hw/igc_edge_detect.sv
// Edge detector for one external interrupt pin with selectable polarity.
// Assumes the pin is asynchronous to clock; the polarity select is on the clock domain.
`timescale 1ns/1ps
`default_nettype none

module igc_edge_detect (
	input  wire logic clock,        // Core clock
	input  wire logic sys_rst,      // Async reset, active high
	input  wire logic pin,          // Raw external pin
	input  wire logic fallingSel,   // 1 falling edge, 0 rising edge
	output var  logic edgePulse     // One-cycle pulse on selected edge
);
	import igc_pkg::*;

	igc_edge_state_type r;
	igc_edge_state_type next_r;

	always_comb begin
		next_r           = r;
		next_r.sync      = {r.sync[1:0], pin};
		next_r.edgePulse = 1'b0;
		// A change counts only once stages two and three agree
		if (r.sync[1] == r.sync[2] && r.sync[2] != r.level) begin
			next_r.level     = r.sync[2];
			next_r.edgePulse = (r.sync[2] == ~fallingSel); // RULE6
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign edgePulse = r.edgePulse;

	a_edge_polarity: assert property (@(posedge clock) disable iff (sys_rst)
		r.edgePulse |-> (r.level == ~$past(fallingSel))) // RULE6
		else $error("edge pulse did not follow polarity select");

endmodule : igc_edge_detect

`default_nettype wire

// >>> hw/igc_interrupt_global_control.sv
// Global interrupt control: trap status flags, global enable, vector table select,
// external edge polarity, and a sticky event status with enable and interrupt output.
// Assumes the core sequencer gives trap events as one-cycle pulses on clock.
//
// Summary of operation
// RULE1 - Stack error trap sets the stack fault flag; it reads clear otherwise. Here a write of one to trap_status_control_1 also sets it.
// RULE2 - Oscillator failure trap sets the oscillator loss flag; it stays zero otherwise. Here a write of one to trap_status_control_1 also sets it.
// RULE3 - Unused bits of both control registers read zero and ignore writes.
// RULE4 - Global enable resets to one; cleared, it blocks interrupts but not traps.
// RULE5 - Interrupt-block status bit reads one while the blocking period is active.
// RULE6 - Edge polarity bits choose falling edge when one, rising when zero; reset zero.
// RULE7 - Alternate vector select bit chooses the alternate table, else the standard.
`timescale 1ns/1ps
`default_nettype none

module igc_interrupt_global_control #(
	parameter int EXT_PINS = 4    // External interrupt inputs 0, 1, 2, 4
) (
	input  wire logic                clock,            // Core clock, 50 MHz
	input  wire logic                sys_rst,          // Async reset, active high
	input  wire logic [3:0]          regAddr,          // Register word offset
	input  wire logic [15:0]         regWriteData,     // Write data
	input  wire logic                regWrite,         // Write strobe
	input  wire logic                regRead,          // Read strobe
	output var  logic [15:0]         regReadData,      // Read data, cycle after strobe
	input  wire logic                stackErrorTrap,   // Stack error trap event pulse
	input  wire logic                oscFailTrap,      // Oscillator failure trap event pulse
	input  wire logic                irqBlockActive,   // Blocking instruction period active
	input  wire logic [EXT_PINS-1:0] extIrqPin,        // External interrupt pins, async
	output var  logic [EXT_PINS-1:0] extIrqReq,        // Gated external interrupt pulses
	output var  logic                trapReq,          // Trap pulse, never gated
	output var  logic                globalIrqEnable,  // Global interrupt enable
	output var  logic                altVectorSelect,  // 1 alternate vector table
	output var  logic                softwareTrapReq,  // Software trap bit
	output var  logic                irq               // Level interrupt output
);
	import igc_pkg::*;

	// ==========================================================
	// State
	igc_state_type      r;
	igc_state_type      next_r;
	logic [EXT_PINS-1:0] edgePulse;
	logic [EVT_WIDTH-1:0] eventSet;
	logic [EVT_WIDTH-1:0] eventClear;
	logic [EVT_WIDTH-1:0] gateMask;
	logic                 writeTrap1;
	logic                 writeConfig;

	// ==========================================================
	// External edge detectors
	genvar gi;
	generate
		for (gi = 0; gi < EXT_PINS; gi++) begin : g_edge
			igc_edge_detect u_edge (
				.clock      (clock),
				.sys_rst    (sys_rst),
				.pin        (extIrqPin[gi]),
				.fallingSel (r.fallingSelect[gi]),
				.edgePulse  (edgePulse[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Next state
	always_comb begin
		next_r      = r;
		writeTrap1  = regWrite && (regAddr == TRAP_STATUS_CONTROL_1_OFS);
		writeConfig = regWrite && (regAddr == INTERRUPT_GLOBAL_CONFIG_OFS);
		eventSet    = {edgePulse, oscFailTrap, stackErrorTrap};
		eventClear  = '0;
		if (regWrite && regAddr == EVENT_CLEAR_OFS) begin
			eventClear = regWriteData[EVT_WIDTH-1:0];
		end

		// Trap flags: software may rewrite them, a trap in the same cycle wins
		if (writeTrap1) begin
			next_r.stackFault = regWriteData[STACK_FAULT_FLAG_BIT];
			next_r.oscLoss    = regWriteData[OSCILLATOR_LOSS_BIT];
		end
		if (stackErrorTrap) begin
			next_r.stackFault = 1'b1; // RULE1
		end
		if (oscFailTrap) begin
			next_r.oscLoss = 1'b1; // RULE2
		end

		// Only implemented bits are taken; the block status bit is never stored
		if (writeConfig) begin
			next_r.globalIrqEnable  = regWriteData[GLOBAL_IRQ_ENABLE_BIT]; // RULE4
			next_r.softwareTrap     = regWriteData[SOFTWARE_TRAP_BIT];
			next_r.altVector        = regWriteData[ALT_VECTOR_TABLE_BIT]; // RULE7
			next_r.fallingSelect[3] = regWriteData[EXT_IRQ4_FALLING_BIT]; // RULE6
			next_r.fallingSelect[2] = regWriteData[EXT_IRQ2_FALLING_BIT]; // RULE6
			next_r.fallingSelect[1] = regWriteData[EXT_IRQ1_FALLING_BIT]; // RULE6
			next_r.fallingSelect[0] = regWriteData[EXT_IRQ0_FALLING_BIT]; // RULE6
		end
		if (regWrite && regAddr == EVENT_ENABLE_OFS) begin
			next_r.eventEnable = regWriteData[EVT_WIDTH-1:0];
		end

		// Sticky status: set wins over clear
		next_r.eventStatus = (r.eventStatus & ~eventClear) | eventSet;

		// Interrupts are held off by the global enable and the block period;
		// traps pass regardless, so software can mask a fault only at irq, through the event enable
		gateMask = {{EXT_COUNT{r.globalIrqEnable && !irqBlockActive}}, 2'b11}; // RULE4
		next_r.extIrqReq = (r.globalIrqEnable && !irqBlockActive) ? edgePulse : '0; // RULE4
		next_r.trapReq   = stackErrorTrap || oscFailTrap; // RULE4
		next_r.irq       = |(r.eventStatus & r.eventEnable & gateMask);

		// Read data stands for one cycle only
		next_r.readData = '0;
		if (regRead) begin
			unique case (regAddr)
				TRAP_STATUS_CONTROL_1_OFS: begin
					next_r.readData[STACK_FAULT_FLAG_BIT] = r.stackFault; // RULE1
					next_r.readData[OSCILLATOR_LOSS_BIT]  = r.oscLoss; // RULE2
				end
				INTERRUPT_GLOBAL_CONFIG_OFS: begin
					next_r.readData[GLOBAL_IRQ_ENABLE_BIT] = r.globalIrqEnable;
					next_r.readData[IRQ_BLOCK_INSTR_BIT]   = irqBlockActive; // RULE5
					next_r.readData[SOFTWARE_TRAP_BIT]     = r.softwareTrap;
					next_r.readData[ALT_VECTOR_TABLE_BIT]  = r.altVector;
					next_r.readData[EXT_IRQ4_FALLING_BIT]  = r.fallingSelect[3];
					next_r.readData[EXT_IRQ2_FALLING_BIT]  = r.fallingSelect[2];
					next_r.readData[EXT_IRQ1_FALLING_BIT]  = r.fallingSelect[1];
					next_r.readData[EXT_IRQ0_FALLING_BIT]  = r.fallingSelect[0];
				end
				EVENT_STATUS_OFS: begin
					next_r.readData[EVT_WIDTH-1:0] = r.eventStatus;
				end
				EVENT_ENABLE_OFS: begin
					next_r.readData[EVT_WIDTH-1:0] = r.eventEnable;
				end
				// Clear register is write-only; unmapped offsets read zero
				default: begin
					next_r.readData = '0; // RULE3
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			r                 <= '0;
			r.globalIrqEnable <= GLOBAL_IRQ_ENABLE_RST; // RULE4
			r.fallingSelect   <= FALLING_SELECT_RST; // RULE6
			r.eventStatus     <= EVENT_RST;
			r.eventEnable     <= EVENT_RST;
		end else begin
			r <= next_r;
		end
	end

	assign regReadData     = r.readData;
	assign extIrqReq       = r.extIrqReq;
	assign trapReq         = r.trapReq;
	assign globalIrqEnable = r.globalIrqEnable;
	assign altVectorSelect = r.altVector;
	assign softwareTrapReq = r.softwareTrap;
	assign irq             = r.irq;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_read_trap1;
		regRead && regAddr == TRAP_STATUS_CONTROL_1_OFS;
	endsequence

	sequence s_read_config;
		regRead && regAddr == INTERRUPT_GLOBAL_CONFIG_OFS;
	endsequence

	sequence s_read_status;
		regRead && regAddr == EVENT_STATUS_OFS;
	endsequence

	sequence s_read_enable;
		regRead && regAddr == EVENT_ENABLE_OFS;
	endsequence

	sequence s_write_clear;
		regWrite && regAddr == EVENT_CLEAR_OFS;
	endsequence

	a_stack_flag_set: assert property ( // RULE1
		stackErrorTrap ##1 s_read_trap1 |=> regReadData[STACK_FAULT_FLAG_BIT])
		else $error("stack fault flag not set after trap");

	a_osc_flag_cause: assert property ( // RULE2
		$rose(r.oscLoss) |-> $past(oscFailTrap) || $past(writeTrap1))
		else $error("oscillator loss flag set without cause");

	a_unused_bits_zero: assert property ( // RULE3
		s_read_config or s_read_trap1 |=> (regReadData & ~(CONFIG_MASK | TRAP1_MASK)) == '0)
		else $error("unimplemented bit read nonzero");

	a_gie_blocks_irq: assert property ( // RULE4
		!r.globalIrqEnable |=> extIrqReq == '0 && trapReq == $past(stackErrorTrap || oscFailTrap))
		else $error("interrupt passed while globally disabled or trap lost");

	a_block_status: assert property ( // RULE5
		s_read_config |=> regReadData[IRQ_BLOCK_INSTR_BIT] == $past(irqBlockActive))
		else $error("block status bit does not follow active period");

	a_polarity_write: assert property ( // RULE6
		writeConfig |=> r.fallingSelect[0] == $past(regWriteData[EXT_IRQ0_FALLING_BIT])
			&& r.fallingSelect[3] == $past(regWriteData[EXT_IRQ4_FALLING_BIT]))
		else $error("polarity select not taken from write");

	a_alt_vector: assert property ( // RULE7
		writeConfig |=> altVectorSelect == $past(regWriteData[ALT_VECTOR_TABLE_BIT]))
		else $error("vector table select not taken from write");

	// ==========================================================
	// Trap flags and unused bits
	a_osc_flag_set: assert property ( // RULE2
		oscFailTrap ##1 s_read_trap1 |=> regReadData[OSCILLATOR_LOSS_BIT])
		else $error("oscillator loss flag not set after trap");

	a_stack_flag_cause: assert property ( // RULE1
		$rose(r.stackFault) |-> $past(stackErrorTrap) || $past(writeTrap1))
		else $error("stack fault flag set without cause");

	a_trap1_unused: assert property ( // RULE3
		s_read_trap1 |=> (regReadData & ~TRAP1_MASK) == 16'h0000)
		else $error("unused trap register bit read nonzero");

	a_config_unused: assert property ( // RULE3
		s_read_config |=> (regReadData & ~CONFIG_MASK) == 16'h0000)
		else $error("unused config register bit read nonzero");

	a_unmapped_zero: assert property ( // RULE3
		regRead && (regAddr == EVENT_CLEAR_OFS || regAddr > EVENT_ENABLE_OFS)
			|=> regReadData == 16'h0000)
		else $error("write-only or unmapped offset read nonzero");

	// Read data must not linger, or a later poll would see stale bits
	a_read_data_idle: assert property (
		!regRead |=> regReadData == 16'h0000)
		else $error("read data present without a read strobe");

	a_event_upper_zero: assert property (
		s_read_status or s_read_enable |=> regReadData[15:EVT_WIDTH] == '0)
		else $error("event register upper bits read nonzero");

	// ==========================================================
	// Gating, enables and configuration
	a_trap_not_gated: assert property ( // RULE4
		stackErrorTrap || oscFailTrap |=> trapReq)
		else $error("trap request lost");

	a_ext_gated: assert property ( // RULE4
		!globalIrqEnable || irqBlockActive |=> extIrqReq == '0)
		else $error("external request passed while gated");

	a_ext_passes: assert property ( // RULE4
		globalIrqEnable && !irqBlockActive && edgePulse != '0 |=> extIrqReq != '0)
		else $error("external request lost while enabled");

	a_enable_write: assert property ( // RULE4
		writeConfig |=> globalIrqEnable == $past(regWriteData[GLOBAL_IRQ_ENABLE_BIT]))
		else $error("global enable not taken from write");

	a_irq_trap_pass: assert property ( // RULE4
		(r.eventStatus[EVT_OSC_BIT:EVT_STACK_BIT]
			& r.eventEnable[EVT_OSC_BIT:EVT_STACK_BIT]) != 2'b00 |=> irq)
		else $error("enabled trap status did not raise the interrupt");

	a_irq_gated: assert property ( // RULE4
		(!globalIrqEnable || irqBlockActive)
			&& r.eventEnable[EVT_OSC_BIT:EVT_STACK_BIT] == 2'b00 |=> !irq)
		else $error("interrupt raised while gated");

	a_irq_open: assert property ( // RULE4
		globalIrqEnable && !irqBlockActive && (r.eventStatus & r.eventEnable) != '0 |=> irq)
		else $error("enabled status did not raise the interrupt");

	a_polarity_mid: assert property ( // RULE6
		writeConfig |=> r.fallingSelect[1] == $past(regWriteData[EXT_IRQ1_FALLING_BIT])
			&& r.fallingSelect[2] == $past(regWriteData[EXT_IRQ2_FALLING_BIT]))
		else $error("polarity select not taken from write");

	a_polarity_hold: assert property ( // RULE6
		!writeConfig |=> $stable(r.fallingSelect))
		else $error("polarity select changed without a write");

	a_alt_vector_hold: assert property ( // RULE7
		!writeConfig |=> $stable(altVectorSelect))
		else $error("vector table select changed without a write");

	a_alt_vector_read: assert property ( // RULE7
		s_read_config |=> regReadData[ALT_VECTOR_TABLE_BIT] == $past(altVectorSelect))
		else $error("vector table select read back wrong");

	a_soft_trap_write: assert property (
		writeConfig |=> softwareTrapReq == $past(regWriteData[SOFTWARE_TRAP_BIT]))
		else $error("software trap bit not taken from write");

	// ==========================================================
	// Sticky event status
	a_status_set_wins: assert property (
		eventSet != '0 |=> (r.eventStatus & $past(eventSet)) == $past(eventSet))
		else $error("event lost from status");

	a_status_cleared: assert property (
		s_write_clear |=> (r.eventStatus & $past(regWriteData[EVT_WIDTH-1:0])
			& ~$past(eventSet)) == '0)
		else $error("status bit survived a clear");

endmodule : igc_interrupt_global_control

`default_nettype wire

// >>> inc/igc_pkg.sv
// Package of the interrupt global control block: register map, field positions, reset values.
// Assumes a 16-bit register port with word offsets and one 50 MHz core clock.
package igc_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] TRAP_STATUS_CONTROL_1_OFS   = 4'h0;
	localparam logic [3:0] INTERRUPT_GLOBAL_CONFIG_OFS = 4'h1;
	localparam logic [3:0] EVENT_STATUS_OFS            = 4'h2;
	localparam logic [3:0] EVENT_CLEAR_OFS             = 4'h3;
	localparam logic [3:0] EVENT_ENABLE_OFS            = 4'h4;

	// ==========================================================
	// Field positions, trap_status_control_1
	localparam int STACK_FAULT_FLAG_BIT   = 2;
	localparam int OSCILLATOR_LOSS_BIT    = 1;
	// Field positions, interrupt_global_config
	localparam int GLOBAL_IRQ_ENABLE_BIT  = 15;
	localparam int IRQ_BLOCK_INSTR_BIT    = 14;
	localparam int SOFTWARE_TRAP_BIT      = 13;
	localparam int ALT_VECTOR_TABLE_BIT   = 8;
	localparam int EXT_IRQ4_FALLING_BIT   = 4;
	localparam int EXT_IRQ2_FALLING_BIT   = 2;
	localparam int EXT_IRQ1_FALLING_BIT   = 1;
	localparam int EXT_IRQ0_FALLING_BIT   = 0;
	// Event status layout: traps in the low bits, external edges above
	localparam int EVT_STACK_BIT          = 0;
	localparam int EVT_OSC_BIT            = 1;
	localparam int EVT_EXT_BASE           = 2;
	localparam int EVT_WIDTH              = 6;
	localparam int EXT_COUNT              = 4;

	// Implemented-bit masks
	localparam logic [15:0] TRAP1_MASK    = 16'h0006;
	localparam logic [15:0] CONFIG_MASK   = 16'hE117;

	// ==========================================================
	// Reset values
	localparam logic       GLOBAL_IRQ_ENABLE_RST = 1'b1;
	localparam logic [3:0] FALLING_SELECT_RST    = 4'h0;
	localparam logic [5:0] EVENT_RST             = 6'h00;

	// ==========================================================
	// Block state
	typedef struct packed {
		logic                 stackFault;
		logic                 oscLoss;
		logic                 globalIrqEnable;
		logic                 softwareTrap;
		logic                 altVector;
		logic [3:0]           fallingSelect;
		logic [EVT_WIDTH-1:0] eventStatus;
		logic [EVT_WIDTH-1:0] eventEnable;
		logic [15:0]          readData;
		logic                 irq;
		logic [3:0]           extIrqReq;
		logic                 trapReq;
	} igc_state_type;

	typedef struct packed {
		logic [2:0] sync;
		logic       level;
		logic       edgePulse;
	} igc_edge_state_type;

endpackage : igc_pkg

// >>> verification/igc_cpu_partner.sv
// Model of the core exception sequencer and the external interrupt pins.
// Assumes one core clock; every output changes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module igc_cpu_partner (
	input  wire logic       clock,           // Core clock
	output var  logic       stackErrorTrap,  // Stack error trap pulse
	output var  logic       oscFailTrap,     // Oscillator failure trap pulse
	output var  logic       irqBlockActive,  // Blocking instruction period
	output var  logic [3:0] extIrqPin        // External pins 0, 1, 2, 4
);
	initial begin
		stackErrorTrap = 1'b0;
		oscFailTrap    = 1'b0;
		irqBlockActive = 1'b0;
		extIrqPin      = 4'h0;
	end

	// ==========================================================
	// Traps come as one-cycle pulses, as the sequencer gives them
	task pulseTrap(input logic stack, input logic osc);
		@(posedge clock);
		stackErrorTrap <= stack;
		oscFailTrap    <= osc;
		@(posedge clock);
		stackErrorTrap <= 1'b0;
		oscFailTrap    <= 1'b0;
	endtask : pulseTrap

	task setBlock(input logic v);
		@(posedge clock);
		irqBlockActive <= v;
	endtask : setBlock

	task setPin(input int idx, input logic v);
		@(posedge clock);
		extIrqPin[idx] <= v;
	endtask : setPin
endmodule : igc_cpu_partner
`default_nettype wire

// >>> verification/igc_interrupt_global_control_tb.sv
// Self-checking bench of the interrupt global control block.
// Assumes the register port of the package and the partner model beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end

module igc_interrupt_global_control_tb;
	import igc_pkg::*;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWriteData = 16'h0000;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic [15:0] regReadData;
	logic        stackErrorTrap, oscFailTrap, irqBlockActive;
	logic [3:0]  extIrqPin, extIrqReq;
	logic        trapReq, globalIrqEnable, altVectorSelect, softwareTrapReq, irq;
	logic [15:0] rd;
	int          num_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;

	always #10 clock = ~clock;

	igc_interrupt_global_control #(.EXT_PINS(4)) dut (.clock(clock), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
		.regRead(regRead), .regReadData(regReadData), .stackErrorTrap(stackErrorTrap),
		.oscFailTrap(oscFailTrap), .irqBlockActive(irqBlockActive), .extIrqPin(extIrqPin),
		.extIrqReq(extIrqReq), .trapReq(trapReq), .globalIrqEnable(globalIrqEnable),
		.altVectorSelect(altVectorSelect), .softwareTrapReq(softwareTrapReq), .irq(irq));

	igc_cpu_partner cpu (.clock(clock), .stackErrorTrap(stackErrorTrap),
		.oscFailTrap(oscFailTrap), .irqBlockActive(irqBlockActive), .extIrqPin(extIrqPin));

	// ==========================================================
	// Register port: one-cycle strobes, read data only in the next cycle
	task regWr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		regAddr <= a; regWriteData <= d; regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask : regWr

	task regRd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		regAddr <= a; regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regReadData;
	endtask : regRd

	// Counts request pulses of one pin over a window longer than the sync delay
	task waitReq(input int idx, input int exp);
		int n;
		n = 0;
		repeat (8) begin
			@(posedge clock);
			#1 if (extIrqReq[idx] === 1'b1) n++;
		end
		`CHECK(n, exp)
	endtask : waitReq

	task test_reset;
		regRd(TRAP_STATUS_CONTROL_1_OFS, rd);   `CHECK(rd, 16'h0000)
		regRd(INTERRUPT_GLOBAL_CONFIG_OFS, rd); `CHECK(rd, 16'h8000)
		`CHECK(globalIrqEnable, 1'b1)
		`CHECK(altVectorSelect, 1'b0)
		$display("test_reset done");
	endtask : test_reset

	task test_unused;
		regWr(INTERRUPT_GLOBAL_CONFIG_OFS, 16'hFFFF);
		regRd(INTERRUPT_GLOBAL_CONFIG_OFS, rd); `CHECK(rd, 16'hA117)
		`CHECK(altVectorSelect, 1'b1)
		`CHECK(softwareTrapReq, 1'b1)
		regWr(INTERRUPT_GLOBAL_CONFIG_OFS, 16'h0000);
		regRd(INTERRUPT_GLOBAL_CONFIG_OFS, rd); `CHECK(rd, 16'h0000)
		`CHECK(altVectorSelect, 1'b0)
		regWr(TRAP_STATUS_CONTROL_1_OFS, 16'hFFFF);
		regRd(TRAP_STATUS_CONTROL_1_OFS, rd);   `CHECK(rd, 16'h0006)
		regWr(TRAP_STATUS_CONTROL_1_OFS, 16'h0000);
		regRd(4'hF, rd);                        `CHECK(rd, 16'h0000)
		$display("test_unused done");
	endtask : test_unused

	// Global enable stays low here: traps must still pass
	task test_traps;
		regWr(EVENT_CLEAR_OFS, 16'h003F);
		regWr(EVENT_ENABLE_OFS, 16'h0001);
		cpu.pulseTrap(1'b1, 1'b0);
		#1 `CHECK(trapReq, 1'b1)
		regRd(TRAP_STATUS_CONTROL_1_OFS, rd);   `CHECK(rd, 16'h0004)
		`CHECK(irq, 1'b1)
		regWr(EVENT_CLEAR_OFS, 16'h0001);
		// The interrupt output follows the status one cycle later
		@(posedge clock);
		#1 `CHECK(irq, 1'b0)
		cpu.pulseTrap(1'b0, 1'b1);
		regRd(TRAP_STATUS_CONTROL_1_OFS, rd);   `CHECK(rd, 16'h0006)
		`CHECK(irq, 1'b0)
		regWr(TRAP_STATUS_CONTROL_1_OFS, 16'h0000);
		regRd(TRAP_STATUS_CONTROL_1_OFS, rd);   `CHECK(rd, 16'h0000)
		$display("test_traps done");
	endtask : test_traps

	task test_edges;
		logic [15:0] sel;
		for (int i = 0; i < 4; i++) begin
			sel = (i == 3) ? 16'h0010 : (16'h0001 << i);
			regWr(INTERRUPT_GLOBAL_CONFIG_OFS, 16'h8000);
			cpu.setPin(i, 1'b1); waitReq(i, 1);
			cpu.setPin(i, 1'b0); waitReq(i, 0);
			regWr(INTERRUPT_GLOBAL_CONFIG_OFS, 16'h8000 | sel);
			regRd(INTERRUPT_GLOBAL_CONFIG_OFS, rd); `CHECK(rd, 16'h8000 | sel)
			cpu.setPin(i, 1'b1); waitReq(i, 0);
			cpu.setPin(i, 1'b0); waitReq(i, 1);
		end
		$display("test_edges done");
	endtask : test_edges

	task test_gating;
		regWr(EVENT_CLEAR_OFS, 16'h003F);
		regWr(INTERRUPT_GLOBAL_CONFIG_OFS, 16'h0000);
		cpu.setPin(0, 1'b1); waitReq(0, 0);
		regRd(EVENT_STATUS_OFS, rd);            `CHECK(rd, 16'h0004)
		regWr(EVENT_ENABLE_OFS, 16'h003C);
		regRd(EVENT_ENABLE_OFS, rd);            `CHECK(rd, 16'h003C)
		`CHECK(irq, 1'b0)
		regWr(INTERRUPT_GLOBAL_CONFIG_OFS, 16'h8000);
		@(posedge clock);
		#1 `CHECK(irq, 1'b1)
		cpu.setBlock(1'b1);
		cpu.setPin(1, 1'b1); waitReq(1, 0);
		regRd(INTERRUPT_GLOBAL_CONFIG_OFS, rd); `CHECK(rd, 16'hC000)
		`CHECK(irq, 1'b0)
		cpu.setBlock(1'b0);
		regRd(INTERRUPT_GLOBAL_CONFIG_OFS, rd); `CHECK(rd, 16'h8000)
		`CHECK(irq, 1'b1)
		$display("test_gating done");
	endtask : test_gating

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// A hang counts as a mismatch; the tests need well under this many cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			tally_and_finish;
		end
	end

	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		test_reset;
		test_unused;
		test_traps;
		test_edges;
		test_gating;
		tally_and_finish;
	end
endmodule : igc_interrupt_global_control_tb
`undef CHECK
`default_nettype wire
